// File: design/tpgio_port.sv
/*
 * Two-pin general-purpose I/O port.
 *
 * Holds the output level register, the direction and drive-style register,
 * the read path that also returns the live pin levels, and the pad control
 * flops of pin one and pin two.
 *
 * Assumes a byte-wide register request port on the system clock with one
 * strobe cycle per access, and pin inputs that are already synchronous to
 * clock. The pad cell outside drives a pin from pin_out while pin_oe is high
 * and leaves the pin to the board while pin_oe is low.
 */
module tpgio_port
(
   input  wire logic                   clock,    // System clock, 125 MHz.
   input  wire logic                   rst,      // Synchronous reset, active high.
   input  wire tpgio_pkg::tpgio_req_t  req,      // Register read or write request.
   output logic [7:0]                  rdata,    // Read data, one cycle after rd_en.
   output logic                        rvalid,   // Read data valid pulse.
   input  wire logic [1:0]             pin_in,   // Live levels of pin one and pin two.
   output logic [1:0]                  pin_out,  // Pad output values.
   output logic [1:0]                  pin_oe    // Pad output enables, high drives.
);

   ////////////////////////////////////////////////////////////////////////////////
   // Local constants and decoding helpers.
   ////////////////////////////////////////////////////////////////////////////////

   // Number of pins that the port serves.
   localparam int NUM_PINS = 2;

   // True when a request address selects the register at reg_addr.
   function automatic logic addr_selects
   (
      input logic [31:0] addr,
      input logic [31:0] reg_addr
   );
      return addr == reg_addr;
   endfunction : addr_selects

   // Clears the bits of a written byte that a register does not implement.
   function automatic logic [7:0] keep_bits
   (
      input logic [7:0] wdata,
      input logic [7:0] mask
   );
      return wdata & mask;
   endfunction : keep_bits

   ////////////////////////////////////////////////////////////////////////////////
   // Registers, their next values and the pad state.
   ////////////////////////////////////////////////////////////////////////////////

   logic [7:0]             out_lvl_q;      // Output level register.
   logic [7:0]             out_lvl_d;
   logic [7:0]             dir_drv_q;      // Direction and drive-style register.
   logic [7:0]             dir_drv_d;
   logic [7:0]             rdata_q;        // Registered read data.
   logic [7:0]             rdata_d;
   logic                   rvalid_q;       // Registered read strobe.
   logic                   rvalid_d;
   logic [1:0]             pin_out_q;      // Pad value flops.
   logic [1:0]             pin_oe_q;       // Pad enable flops.
   tpgio_pkg::tpgio_pins_t pad_d;          // Live levels and next pad control.

   ////////////////////////////////////////////////////////////////////////////////
   // Address decoding.
   ////////////////////////////////////////////////////////////////////////////////

   wire                    sel_readback;
   wire                    sel_output;
   wire                    sel_dir_drive;
   wire                    wr_output;
   wire                    wr_dir_drive;

   assign sel_readback  = addr_selects(req.addr, tpgio_pkg::ADDR_LEVEL_READBACK);
   assign sel_output    = addr_selects(req.addr, tpgio_pkg::ADDR_OUTPUT_LEVEL);
   assign sel_dir_drive = addr_selects(req.addr, tpgio_pkg::ADDR_DIR_AND_DRIVE);

   // The readback register has no write path, so writes to it fall away.
   assign wr_output     = req.wr_en & sel_output;
   assign wr_dir_drive  = req.wr_en & sel_dir_drive;

   ////////////////////////////////////////////////////////////////////////////////
   // Register write path.
   ////////////////////////////////////////////////////////////////////////////////

   // Bits that a register does not implement are stored as zero and so read as zero.
   assign out_lvl_d = wr_output    ? keep_bits(req.wdata, tpgio_pkg::MASK_OUTPUT_LEVEL)
                                   : out_lvl_q;
   assign dir_drv_d = wr_dir_drive ? keep_bits(req.wdata, tpgio_pkg::MASK_DIR_DRIVE)
                                   : dir_drv_q;

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         out_lvl_q <= tpgio_pkg::RST_OUTPUT_LEVEL;
         dir_drv_q <= tpgio_pkg::RST_DIR_AND_DRIVE;
      end
      else
      begin
         out_lvl_q <= out_lvl_d;
         dir_drv_q <= dir_drv_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Register fields by pin.
   ////////////////////////////////////////////////////////////////////////////////

   wire                    pin_one_drive_value;
   wire                    pin_two_drive_value;
   wire                    pin_one_is_input;
   wire                    pin_two_is_input;
   wire                    pin_one_open_drain;
   wire                    pin_two_open_drain;
   wire                    pin_one_level;
   wire                    pin_two_level;

   wire [NUM_PINS-1:0]     drive_value;
   wire [NUM_PINS-1:0]     is_input;
   wire [NUM_PINS-1:0]     open_drain;
   wire [NUM_PINS-1:0]     drive_enable;
   wire [NUM_PINS-1:0]     drive_level;

   assign pin_one_drive_value = out_lvl_q[tpgio_pkg::POS_PIN_ONE_DRIVE_VALUE];
   assign pin_two_drive_value = out_lvl_q[tpgio_pkg::POS_PIN_TWO_DRIVE_VALUE];
   assign pin_one_is_input    = dir_drv_q[tpgio_pkg::POS_PIN_ONE_IS_INPUT];
   assign pin_two_is_input    = dir_drv_q[tpgio_pkg::POS_PIN_TWO_IS_INPUT];
   assign pin_one_open_drain  = dir_drv_q[tpgio_pkg::POS_PIN_ONE_OPEN_DRAIN];
   assign pin_two_open_drain  = dir_drv_q[tpgio_pkg::POS_PIN_TWO_OPEN_DRAIN];

   assign drive_value = {pin_two_drive_value, pin_one_drive_value};
   assign is_input    = {pin_two_is_input, pin_one_is_input};
   assign open_drain  = {pin_two_open_drain, pin_one_open_drain};

   ////////////////////////////////////////////////////////////////////////////////
   // Pad control of each pin.
   ////////////////////////////////////////////////////////////////////////////////

   for (genvar p = 0; p < NUM_PINS; p++)
   begin : g_pin
      wire push_pull_on;
      wire pull_low_on;

      // Push-pull drives both levels; open-drain only pulls low and otherwise floats.
      assign push_pull_on    = ~is_input[p] & ~open_drain[p];
      assign pull_low_on     = ~is_input[p] & open_drain[p] & ~drive_value[p];
      assign drive_enable[p] = push_pull_on | pull_low_on;
      assign drive_level[p]  = drive_value[p] & ~open_drain[p];
   end : g_pin

   // An input pin keeps its enable low, so its pad value is then only a don't-care.
   assign pad_d = '{in_val: pin_in, out_val: drive_level, out_en: drive_enable};

   ////////////////////////////////////////////////////////////////////////////////
   // Read path.
   ////////////////////////////////////////////////////////////////////////////////

   wire [7:0]              level_byte;
   wire [7:0]              read_word;

   assign pin_one_level = pad_d.in_val[tpgio_pkg::POS_PIN_ONE_LEVEL];
   assign pin_two_level = pad_d.in_val[tpgio_pkg::POS_PIN_TWO_LEVEL];

   // Levels are read back in either direction, so a driving output pin shows its own pad and a released open-drain pin the board level.
   assign level_byte = {6'h00, pin_two_level, pin_one_level};

   assign read_word = sel_readback  ? level_byte :
                      sel_output    ? out_lvl_q  :
                      sel_dir_drive ? dir_drv_q  :
                                      8'h00;

   // Read data stays zero outside its one-cycle answer, so readers may OR it in.
   assign rdata_d  = req.rd_en ? read_word : 8'h00;
   assign rvalid_d = req.rd_en;

   ////////////////////////////////////////////////////////////////////////////////
   // Answer and pad flops.
   ////////////////////////////////////////////////////////////////////////////////

   // The answer comes exactly one cycle after the read strobe.
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         rdata_q  <= 8'h00;
         rvalid_q <= 1'h0;
      end
      else
      begin
         rdata_q  <= rdata_d;
         rvalid_q <= rvalid_d;
      end
   end

   // Pads follow a register write one cycle after the register itself changes.
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         pin_out_q <= 2'h0;
         pin_oe_q  <= 2'h0;
      end
      else
      begin
         pin_out_q <= pad_d.out_val;
         pin_oe_q  <= pad_d.out_en;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs.
   ////////////////////////////////////////////////////////////////////////////////

   assign rdata   = rdata_q;
   assign rvalid  = rvalid_q;
   assign pin_out = pin_out_q;
   assign pin_oe  = pin_oe_q;

endmodule : tpgio_port

// File: inc/tpgio_pkg.sv
/*
 * Constants and types for the two-pin general-purpose I/O port.
 * Assumes an internal byte-wide register port on the system clock.
 */
package tpgio_pkg;

   localparam logic [31:0] ADDR_LEVEL_READBACK = 32'h4000_0218;
   localparam logic [31:0] ADDR_OUTPUT_LEVEL   = 32'h4000_0219;
   localparam logic [31:0] ADDR_DIR_AND_DRIVE  = 32'h4000_021A;

   localparam int POS_PIN_ONE_LEVEL       = 0;
   localparam int POS_PIN_TWO_LEVEL       = 1;
   localparam int POS_PIN_ONE_DRIVE_VALUE = 0;
   localparam int POS_PIN_TWO_DRIVE_VALUE = 1;
   localparam int POS_PIN_ONE_IS_INPUT    = 0;
   localparam int POS_PIN_TWO_IS_INPUT    = 1;
   localparam int POS_PIN_ONE_OPEN_DRAIN  = 2;
   localparam int POS_PIN_TWO_OPEN_DRAIN  = 3;

   localparam logic [7:0] RST_OUTPUT_LEVEL  = 8'h00;
   localparam logic [7:0] RST_DIR_AND_DRIVE = 8'h03;
   localparam logic [7:0] MASK_OUTPUT_LEVEL = 8'h03;
   localparam logic [7:0] MASK_DIR_DRIVE    = 8'h0F;

   typedef struct packed {
      logic        wr_en;
      logic        rd_en;
      logic [31:0] addr;
      logic [7:0]  wdata;
   } tpgio_req_t;

   typedef struct packed {
      logic [1:0] in_val;
      logic [1:0] out_val;
      logic [1:0] out_en;
   } tpgio_pins_t;

endpackage : tpgio_pkg

// File: tb/tpgio_board.sv
/* Board at the two pins: a pad that drives wins, else the board level shows. */
module tpgio_board (input wire logic [1:0] pin_out, pin_oe, ext, output logic [1:0] pin_in);
   timeunit 1ns;
   timeprecision 1ps;
   assign pin_in = pin_oe & pin_out | ~pin_oe & ext;
endmodule : tpgio_board

// File: tb/tpgio_port_properties.sv
/* Checker of tpgio_port; sees only its ports and is bound to every instance. */
module tpgio_port_properties (input wire logic clock, rst, input wire tpgio_pkg::tpgio_req_t req,
   input wire logic [7:0] rdata, input wire logic rvalid, input wire logic [1:0] pin_in, pin_out, pin_oe);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] d_q;
   logic [1:0] o_q;
   wire [1:0] lo = req.addr[1:0];
   wire hit = req.addr[31:2] == 30'h1000_0086, r = req.rd_en & !req.wr_en & hit;
   wire [1:0] e_oe = ~d_q[1:0] & (~d_q[3:2] | ~o_q), e_po = ~d_q[3:2] & o_q;
   always_ff @(posedge clock) d_q <= rst ? 4'h3 : req.wr_en & hit & lo == 2'h2 ? req.wdata[3:0] : d_q;
   always_ff @(posedge clock) o_q <= rst ? 2'h0 : req.wr_en & hit & lo == 2'h1 ? req.wdata[1:0] : o_q;
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   a_rd_pulse: assert property (req.rd_en |=> rvalid) else $error("no rvalid");
   a_rd_idle: assert property (!req.rd_en |=> rdata == 8'h00) else $error("stray rdata");
   a_rd_level: assert property (r & lo == 2'h0 |=> rdata == {6'h00, $past(pin_in)}) else $error("level");
   a_rd_out: assert property (r & lo == 2'h1 |=> rdata == {6'h00, $past(o_q)}) else $error("out");
   a_rd_dir: assert property (r & lo == 2'h2 |=> rdata == {4'h0, $past(d_q)}) else $error("dir");
   a_oe_one: assert property (pin_oe[0] == $past(e_oe[0])) else $error("oe one");
   a_oe_two: assert property (pin_oe[1] == $past(e_oe[1])) else $error("oe two");
   a_drive_val: assert property (pin_out == $past(e_po)) else $error("drive");
   cover property (pin_oe == 2'h3);
   cover property (pin_oe == 2'h1 && pin_out == 2'h0);
   cover property (r & lo == 2'h3);
endmodule : tpgio_port_properties
bind tpgio_port tpgio_port_properties u_tpgio_port_properties (.clock, .rst, .req, .rdata, .rvalid,
   .pin_in, .pin_out, .pin_oe);

// File: tb/tpgio_port_test.sv
/* Bench for tpgio_port; rows hold dir, out, board level, oe, pad value, readback. */
module tpgio_port_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'h0, rst = 1'h1, rvalid;
   logic [1:0] ext = 2'h0, pin_in, pin_out, pin_oe;
   logic [7:0] rdata;
   tpgio_pkg::tpgio_req_t req = '0;
   int failures = 0, num_checks = 0;
   logic [23:0] rows [6] = '{24'h000135, 24'h0C02D2, 24'h03034D, 24'h060092, 24'h0902C3, 24'h00023A};
   always #4 clock = ~clock;
   tpgio_port u_tpgio_port (.clock, .rst, .req, .rdata, .rvalid, .pin_in, .pin_out, .pin_oe);
   tpgio_board u_tpgio_board (.pin_out, .pin_oe, .ext, .pin_in);
   task report_and_stop;
      if (failures == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : report_and_stop
   task chk(input logic [7:0] g, e);
      num_checks++;
      if (g !== e) failures++;
      if (g !== e) $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
   endtask : chk
   task xfer(input logic w, input logic [7:0] a, d, e);
      req = '{w, !w, {24'h40_0002, a}, d};
      @(posedge clock) #1 req = '0;
      if (!w) chk(rvalid ? rdata : 8'hEE, e);
      @(posedge clock) #1;
   endtask : xfer
   initial
   begin
      repeat (10) @(posedge clock);
      #1 rst = 1'h0;
      xfer(1'h0, 8'h19, 8'h00, 8'h00);
      xfer(1'h0, 8'h1A, 8'h00, 8'h03);
      foreach (rows[i])
      begin
         ext = rows[i][7:6];
         xfer(1'h1, 8'h1A, rows[i][23:16], 8'h00);
         xfer(1'h1, 8'h19, rows[i][15:8], 8'h00);
         chk({2'h0, pin_oe, 2'h0, pin_out}, {2'h0, rows[i][5:4], 2'h0, rows[i][3:2]});
         xfer(1'h0, 8'h18, 8'h00, {6'h00, rows[i][1:0]});
      end
      xfer(1'h1, 8'h19, 8'hFF, 8'h00);
      xfer(1'h0, 8'h19, 8'h00, 8'h03);
      xfer(1'h1, 8'h1A, 8'hFF, 8'h00);
      xfer(1'h0, 8'h1A, 8'h00, 8'h0F);
      xfer(1'h0, 8'h1B, 8'h00, 8'h00);
      xfer(1'h1, 8'h1A, 8'h00, 8'h00);
      chk({2'h0, pin_oe, 2'h0, pin_out}, 8'h33);
      rst = 1'h1;
      repeat (3) @(posedge clock);
      #1 rst = 1'h0;
      chk({2'h0, pin_oe, 2'h0, pin_out}, 8'h00);
      xfer(1'h0, 8'h1A, 8'h00, 8'h03);
      xfer(1'h0, 8'h19, 8'h00, 8'h00);
      report_and_stop;
   end
   initial
   begin
      #4000 failures++;
      report_and_stop;
   end
endmodule : tpgio_port_test
